// File: sri_pkg.sv
// Purpose: shared constants and types for the byte-wide serial port block
// Assumes: 32-bit APB data, registers one word each at four times their index
// Notes:   field positions follow the control and control/status layouts
package sri_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_DATA   = 8'h21;
	localparam logic [7:0] IDX_CTRL   = 8'h22;
	localparam logic [7:0] IDX_STATUS = 8'h23;
	localparam logic [9:0] ADDR_DATA   = {IDX_DATA, 2'b00};
	localparam logic [9:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET   = 8'h00;

	// half periods of sck in pclk cycles, per rate code
	localparam logic [6:0] HALF_DIV4   = 7'h02;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV16  = 7'h08;
	localparam logic [6:0] HALF_DIV32  = 7'h10;
	localparam logic [6:0] HALF_DIV64  = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

	typedef struct packed {
		logic       xfer_irq_enable;
		logic       port_pin_enable;
		logic       div2_disable;
		logic       controller_select;
		logic       clock_idle_level;
		logic       capture_phase;
		logic       rate_sel_hi;
		logic       rate_sel_lo;
	} sri_ctrl_type;

	typedef struct packed {
		logic       transfer_done_flag;
		logic       write_clash_flag;
		logic       overrun_flag;
		logic       mode_fault_flag;
		logic       reserved;
		logic       output_block;
		logic       select_source_soft;
		logic       select_level_soft;
	} sri_status_type;

	typedef enum logic [0:0] {
		SRI_IDLE = 1'b0,
		SRI_RUN  = 1'b1
	} sri_state_type;

endpackage

// File: sri_core.sv
// Purpose: byte-wide synchronous serial port, controller or target, APB registers
// Assumes: pins synchronous to pclk; target sck at most pclk/4
// Notes:   pin output enables are active low
// Operation
// - interrupt enable raises interrupt while done, mode fault or overrun flag is set
// - port enable connects serial pin functions; cleared by reset
// - controller seeing select low sets mode fault, clears enable and controller bits
// - mode fault clears on status read with flag set, then control write
// - controller sck is pclk divided by 4 to 128; target ignores rate bits
// - controller select makes sck an output and swaps mosi and miso roles
// - idle level bit sets sck idle low or high in both modes
// - phase 0 captures on first sck edge, phase 1 on second
// - done flag sets at byte end; clears on status read then data access
// - data writes ignored while done flag set until status read
// - data write during transfer sets write clash; transfer continues
// - write clash never raises the interrupt
// - overrun sets when byte completes with done set; status read clears it
// - output block stops driving mosi as controller, miso as target
// - soft select source ignores the select pin and uses the soft level
// - soft select level 0 selects, 1 deselects
// - controller data write starts one byte exchange
// - received byte copied to read buffer at completion unless done flag still set; reads return buffer
// - data write loads the shift register directly
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module sri_core
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   serial_irq,
	output logic                   pin_func_enable,
	output logic                   select_pin_free,
	input  wire logic              sck_in,
	output logic                   sck_out,
	output logic                   sck_oe_n,
	input  wire logic              mosi_in,
	output logic                   mosi_out,
	output logic                   mosi_oe_n,
	input  wire logic              miso_in,
	output logic                   miso_out,
	output logic                   miso_oe_n,
	input  wire logic              select_n_in
);

	// bits 9:0 are decoded, so the address bus must be at least 10 bits wide even though the registers sit below 0x090
	if (ADDR_W < 10)
	begin : g_addr_w_check
		$error("sri_core: ADDR_W must be at least 10");
	end

	sri_pkg::sri_ctrl_type   ctrl_q, ctrl_d;
	sri_pkg::sri_status_type stat_q, stat_d;
	sri_pkg::sri_state_type  state_q, state_d;
	logic [7:0]  shift_q, shift_d;
	logic [7:0]  rxbuf_q, rxbuf_d;
	logic        rxbit_q, rxbit_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [4:0]  edges_q, edges_d;
	logic [6:0]  div_q, div_d;
	logic        sck_q, sck_d;
	logic        sck_prev_q;
	logic        stat_seen_q, stat_seen_d;
	logic        mode_fault_flag_seen_q, mode_fault_flag_seen_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        irq_q, irq_d;
	logic        sck_oe_n_q, mosi_oe_n_q, miso_oe_n_q;

	logic        access;
	logic        wr_data, wr_ctrl, wr_stat, rd_data, rd_stat;
	logic        mapped;
	logic        sel_low;
	logic        master;
	logic        busy;
	logic        edge_go;
	logic        edge_level;
	logic        serial_in;
	logic [6:0]  half;

	localparam sri_pkg::sri_state_type SRI_RUN_C  = sri_pkg::SRI_RUN;
	localparam sri_pkg::sri_state_type SRI_IDLE_C = sri_pkg::SRI_IDLE;

	// rate code {div2_disable, hi, lo}; unlisted codes fall back to the slowest
	function automatic logic [6:0] half_period(input logic [2:0] code);
		logic [6:0] h;
		h = sri_pkg::HALF_DIV128;
		unique case (code)
			3'b100: h = sri_pkg::HALF_DIV4;
			3'b000: h = sri_pkg::HALF_DIV8;
			3'b001: h = sri_pkg::HALF_DIV16;
			3'b110: h = sri_pkg::HALF_DIV32;
			3'b010: h = sri_pkg::HALF_DIV64;
			default: h = sri_pkg::HALF_DIV128;
		endcase
		return h;
	endfunction

	// side effects land only on the edge where pready is seen high
	assign access  = psel & penable & pready_q;
	assign mapped  = (paddr[9:0] == sri_pkg::ADDR_DATA) | (paddr[9:0] == sri_pkg::ADDR_CTRL)
		| (paddr[9:0] == sri_pkg::ADDR_STATUS);
	assign wr_data = access & pwrite & (paddr[9:0] == sri_pkg::ADDR_DATA);
	assign wr_ctrl = access & pwrite & (paddr[9:0] == sri_pkg::ADDR_CTRL);
	assign wr_stat = access & pwrite & (paddr[9:0] == sri_pkg::ADDR_STATUS);
	assign rd_data = access & ~pwrite & (paddr[9:0] == sri_pkg::ADDR_DATA);
	assign rd_stat = access & ~pwrite & (paddr[9:0] == sri_pkg::ADDR_STATUS);

	// soft select frees the pin; the select level then comes from the status bits
	assign sel_low   = stat_q.select_source_soft ? ~stat_q.select_level_soft : ~select_n_in;
	assign master    = ctrl_q.controller_select;
	assign serial_in = master ? miso_in : mosi_in;
	assign half      = half_period({ctrl_q.div2_disable, ctrl_q.rate_sel_hi,
		ctrl_q.rate_sel_lo});
	// a target counts as busy once the first bit of a byte has been taken under select
	assign busy      = (state_q == SRI_RUN_C) | (~master & sel_low & (cnt_q != 4'h0));

	// one sck edge this cycle, with the level that sck takes after it
	always_comb
	begin
		edge_go    = 1'b0;
		edge_level = sck_q;
		if (master && state_q == SRI_RUN_C && div_q == half - 7'h01)
		begin
			edge_go    = 1'b1;
			edge_level = ~sck_q;
		end
		else if (!master && ctrl_q.port_pin_enable && sel_low && sck_in != sck_prev_q)
		begin
			edge_go    = 1'b1;
			edge_level = sck_in;
		end
	end

	always_comb
	begin
		ctrl_d      = ctrl_q;
		stat_d      = stat_q;
		state_d     = state_q;
		shift_d     = shift_q;
		rxbuf_d     = rxbuf_q;
		rxbit_d     = rxbit_q;
		cnt_d       = cnt_q;
		edges_d     = edges_q;
		div_d       = div_q;
		sck_d       = sck_q;
		stat_seen_d = stat_seen_q;
		mode_fault_flag_seen_d = mode_fault_flag_seen_q;
		pready_d    = psel & penable & ~pready_q;
		pslverr_d   = 1'b0;
		prdata_d    = 32'h0000_0000;

		// register reads, taken while the access phase is being answered
		if (psel && penable && !pready_q)
		begin
			// unmapped offsets answer with an error and change nothing
			pslverr_d = ~mapped;
			if (!pwrite && paddr[9:0] == sri_pkg::ADDR_DATA)
				prdata_d = {24'h00_0000, rxbuf_q};
			else if (!pwrite && paddr[9:0] == sri_pkg::ADDR_CTRL)
				prdata_d = {24'h00_0000, ctrl_q};
			else if (!pwrite && paddr[9:0] == sri_pkg::ADDR_STATUS)
				// reserved bit always reads back as zero
				prdata_d = {24'h00_0000, stat_q[7:4], 1'b0, stat_q[2:0]};
		end

		// flag clears first so that a hardware set below wins in the same cycle
		if (rd_stat)
		begin
			stat_seen_d         = 1'b1;
			stat_d.overrun_flag = 1'b0;
			if (stat_q.mode_fault_flag)
				mode_fault_flag_seen_d = 1'b1;
		end
		if ((rd_data || wr_data) && stat_seen_q)
		begin
			stat_d.transfer_done_flag = 1'b0;
			stat_d.write_clash_flag   = 1'b0;
			stat_seen_d               = 1'b0;
		end

		if (wr_stat)
		begin
			// reserved bit is dropped; software is expected to write it zero
			stat_d.output_block       = pwdata[2];
			stat_d.select_source_soft = pwdata[1];
			stat_d.select_level_soft  = pwdata[0];
		end

		if (wr_ctrl)
		begin
			ctrl_d = pwdata[7:0];
			if (mode_fault_flag_seen_q)
			begin
				stat_d.mode_fault_flag = 1'b0;
				mode_fault_flag_seen_d            = 1'b0;
			end
			else if (stat_q.mode_fault_flag)
			begin
				// enable and controller stay off until the fault is cleared
				ctrl_d.port_pin_enable   = 1'b0;
				ctrl_d.controller_select = 1'b0;
			end
			// leaving enable or swapping mode drops a byte in flight
			if (!pwdata[6] || pwdata[4] != ctrl_q.controller_select)
			begin
				state_d = SRI_IDLE_C;
				cnt_d   = 4'h0;
				sck_d   = pwdata[3];
			end
			else if (state_q == SRI_IDLE_C)
				sck_d = pwdata[3];
		end

		// data write: blocked while done is pending, clash while busy
		if (wr_data && !(stat_q.transfer_done_flag && !stat_seen_q))
		begin
			if (busy)
				stat_d.write_clash_flag = 1'b1;
			else
			begin
				// no holding buffer: the byte goes straight to the shift register
				shift_d = pwdata[7:0];
				if (master && ctrl_q.port_pin_enable)
				begin
					state_d = SRI_RUN_C;
					div_d   = 7'h00;
					edges_d = 5'h00;
					cnt_d   = 4'h0;
					sck_d   = ctrl_q.clock_idle_level;
				end
			end
		end

		// divider restarts at every sck edge so both half periods are equal
		if (master && state_q == SRI_RUN_C)
			div_d = edge_go ? 7'h00 : div_q + 7'h01;

		if (edge_go)
		begin
			if (master)
			begin
				sck_d   = edge_level;
				edges_d = edges_q + 5'h01;
				// both sck edges are counted; the run stops after the last one
				if (edges_q == sri_pkg::EDGES_PER_BYTE - 5'h01)
					state_d = SRI_IDLE_C;
			end
			// capture edge is the one leaving idle when phase is 0
			if (edge_level == ~(ctrl_q.clock_idle_level ^ ctrl_q.capture_phase))
			begin
				rxbit_d = serial_in;
				if (cnt_q == sri_pkg::BITS_PER_BYTE - 4'h1)
				begin
					cnt_d   = 4'h0;
					shift_d = {shift_q[6:0], serial_in};
					// on overrun the buffer keeps the byte software has not fetched yet
					if (stat_q.transfer_done_flag)
						stat_d.overrun_flag = 1'b1;
					else
						rxbuf_d = {shift_q[6:0], serial_in};
					stat_d.transfer_done_flag = 1'b1;
				end
				else
					cnt_d = cnt_q + 4'h1;
			end
			else if (cnt_q != 4'h0)
				shift_d = {shift_q[6:0], rxbit_q};
		end

		// a deselected target forgets any partial byte
		if (!master && !sel_low)
			cnt_d = 4'h0;

		// the fault wins over a same-cycle control write, so the mode cannot be kept
		if (master && ctrl_q.port_pin_enable && sel_low)
		begin
			stat_d.mode_fault_flag   = 1'b1;
			ctrl_d.port_pin_enable   = 1'b0;
			ctrl_d.controller_select = 1'b0;
			state_d                  = SRI_IDLE_C;
			cnt_d                    = 4'h0;
			sck_d                    = ctrl_q.clock_idle_level;
		end

		// write clash deliberately left out of the interrupt
		irq_d = ctrl_q.xfer_irq_enable & (stat_q.transfer_done_flag
			| stat_q.mode_fault_flag | stat_q.overrun_flag);
	end

	// enables are taken from the next state so pins switch together with the mode bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q      <= sri_pkg::CTRL_RESET;
			stat_q      <= sri_pkg::STATUS_RESET;
			state_q     <= SRI_IDLE_C;
			shift_q     <= sri_pkg::DATA_RESET;
			rxbuf_q     <= sri_pkg::DATA_RESET;
			rxbit_q     <= 1'b0;
			cnt_q       <= 4'h0;
			edges_q     <= 5'h00;
			div_q       <= 7'h00;
			sck_q       <= 1'b0;
			sck_prev_q  <= 1'b0;
			stat_seen_q <= 1'b0;
			mode_fault_flag_seen_q <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			irq_q       <= 1'b0;
			sck_oe_n_q  <= 1'b1;
			mosi_oe_n_q <= 1'b1;
			miso_oe_n_q <= 1'b1;
		end
		else if (clk_en)
		begin
			ctrl_q      <= ctrl_d;
			stat_q      <= stat_d;
			state_q     <= state_d;
			shift_q     <= shift_d;
			rxbuf_q     <= rxbuf_d;
			rxbit_q     <= rxbit_d;
			cnt_q       <= cnt_d;
			edges_q     <= edges_d;
			div_q       <= div_d;
			sck_q       <= sck_d;
			// the pin is tracked even while disabled, so enabling sees no false edge
			sck_prev_q  <= sck_in;
			stat_seen_q <= stat_seen_d;
			mode_fault_flag_seen_q <= mode_fault_flag_seen_d;
			prdata_q    <= prdata_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			irq_q       <= irq_d;
			sck_oe_n_q  <= ~(ctrl_d.port_pin_enable & ctrl_d.controller_select);
			mosi_oe_n_q <= ~(ctrl_d.port_pin_enable & ctrl_d.controller_select
				& ~stat_d.output_block);
			miso_oe_n_q <= ~(ctrl_d.port_pin_enable & ~ctrl_d.controller_select
				& ~stat_d.output_block & sel_low);
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign serial_irq      = irq_q;
	assign pin_func_enable = ctrl_q.port_pin_enable;
	assign select_pin_free = stat_q.select_source_soft;
	assign sck_out         = sck_q;
	assign sck_oe_n        = sck_oe_n_q;
	// mosi and miso share the shift msb; only the enables tell the two apart
	assign mosi_out        = shift_q[7];
	assign mosi_oe_n       = mosi_oe_n_q;
	assign miso_out        = shift_q[7];
	assign miso_oe_n       = miso_oe_n_q;

endmodule

// File: sri_core_monitor.sv
// Purpose: port checker for the serial port block
// Assumes: clk_en held high
// Notes:   bound to the core from the bench top file
`timescale 1ns/100ps
module sri_core_monitor
#(
	parameter int ADDR_W = 12
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pin_func_enable,
	input wire logic        select_pin_free,
	input wire logic        sck_out,
	input wire logic        sck_oe_n,
	input wire logic        miso_oe_n,
	input wire logic        mosi_oe_n,
	input wire logic        select_n_in
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	a_one_wait: assert property (s_setup ##1 s_wait |=> pready)
		else $error("no answer after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0000_00)
		else $error("read data upper bits not zero");
	a_pins_off: assert property (!pin_func_enable && $past(!pin_func_enable) |->
		sck_oe_n && mosi_oe_n && miso_oe_n)
		else $error("pin driven while port disabled");
	a_ctrl_no_miso: assert property (!sck_oe_n |-> miso_oe_n)
		else $error("controller drives miso");
	a_fault_drop: assert property (!sck_oe_n && !select_pin_free && !select_n_in
		|-> ##[1:6] sck_oe_n)
		else $error("controller kept after select low");
	a_sck_half: assert property ($changed(sck_out) && !sck_oe_n |=> $stable(sck_out))
		else $error("sck faster than pclk/4");
endmodule

// File: sri_peer.sv
// Purpose: target peer on the serial link, polarity 0 phase 0
// Assumes: sck at most pclk/4, seen through pclk
// Notes:   miso shows the inverse of its shift msb while active is low
`timescale 1ns/100ps
module sri_peer
(
	input wire logic        pclk,
	input wire logic        sck,
	input wire logic        mosi,
	input wire logic        active,
	input wire logic        load,
	input wire logic [7:0]  tx_byte,
	output logic            miso,
	output logic [7:0]      rx_byte
);
	logic       sck_q;
	logic       mosi_q;
	logic [7:0] sh_q;
	initial rx_byte = 8'h00;
	always @(posedge pclk)
	begin
		sck_q <= sck;
		// mosi as it stood at the sck edge, since the edge itself is seen one pclk late
		mosi_q <= mosi;
		if (load)
			sh_q <= tx_byte;
		else if (sck && !sck_q)
			rx_byte <= {rx_byte[6:0], mosi_q};
		else if (!sck && sck_q)
			sh_q <= {sh_q[6:0], 1'b0};
	end
	assign miso = active ? sh_q[7] : ~sh_q[7];
endmodule

// File: sri_core_tb.sv
// Purpose: self-checking bench for the serial port block
// Assumes: one wait state APB answer, peer in polarity 0 phase 0
// Notes:   clk_en tied high; sck and mosi wires pulled to idle
`timescale 1ns/100ps
module sri_core_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        select_n_in = 1'b1;
	logic        load = 1'b0;
	logic [7:0]  tx_byte = 8'h00;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, serial_irq, pin_func_enable, select_pin_free;
	logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
	logic        sck_w, mosi_w, miso_w;
	logic [7:0]  rx_byte;
	int          error_cnt = 0;
	int          checks_done = 0;
	assign sck_w = sck_oe_n ? 1'b0 : sck_out;
	assign mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
	sri_core #(.ADDR_W(12)) sri_core_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_irq(serial_irq),
		.pin_func_enable(pin_func_enable), .select_pin_free(select_pin_free),
		.sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w),
		.mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
		.miso_out(miso_out), .miso_oe_n(miso_oe_n), .select_n_in(select_n_in));
	sri_peer sri_peer_i (.pclk(pclk), .sck(sck_w), .mosi(mosi_w), .active(!sck_oe_n),
		.load(load), .tx_byte(tx_byte), .miso(miso_w), .rx_byte(rx_byte));
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task bail(input string nm);
		$display("CHECK FAILED %s exp done got timeout", nm);
		error_cnt++;
		summarize;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, a};
		pwdata <= {24'h0000_00, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			bail("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rchk(input logic [9:0] a, input logic [7:0] e, input string nm);
		apb(1'b0, a, 8'h00);
		chk(nm, {8'h00, e}, rd[15:0]);
	endtask
	task t_reset;
		rchk(sri_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
		rchk(sri_pkg::ADDR_STATUS, 8'h00, "status reset");
		chk("pin func", 16'h0000, 16'(pin_func_enable));
		apb(1'b0, 10'h000, 8'h00);
		chk("unmapped err", 16'h0001, 16'(err));
		$display("test reset done");
	endtask
	task t_rates;
		logic [2:0] codes [6];
		logic [6:0] halves [6];
		int         n, cnt, first, last;
		logic       s;
		codes = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
		halves = '{sri_pkg::HALF_DIV4, sri_pkg::HALF_DIV8, sri_pkg::HALF_DIV16,
			sri_pkg::HALF_DIV32, sri_pkg::HALF_DIV64, sri_pkg::HALF_DIV128};
		for (int i = 0; i < 6; i++)
		begin
			tx_byte <= 8'h3C ^ 8'(i);
			load <= 1'b1;
			apb(1'b1, sri_pkg::ADDR_CTRL, {2'b01, codes[i][2], 3'b100, codes[i][1:0]});
			load <= 1'b0;
			apb(1'b0, sri_pkg::ADDR_STATUS, 8'h00);
			apb(1'b1, sri_pkg::ADDR_DATA, 8'hA5 ^ 8'(i));
			s = sck_out;
			cnt = 0;
			n = 0;
			first = 0;
			last = 0;
			while (cnt < 16 && n < 3000)
			begin
				@(posedge pclk);
				n++;
				if (sck_out !== s)
				begin
					cnt++;
					if (cnt == 1)
						first = n;
					last = n;
					s = sck_out;
				end
			end
			if (cnt < 16)
				bail("sck edges");
			chk("sck span", 16'(15 * halves[i]), 16'(last - first));
			chk("sck idle", 16'h0000, 16'(sck_out));
			chk("peer rx", 16'(8'hA5 ^ 8'(i)), 16'(rx_byte));
			rchk(sri_pkg::ADDR_STATUS, 8'h80, "done");
			rchk(sri_pkg::ADDR_DATA, 8'h3C ^ 8'(i), "rx buffer");
		end
		$display("test rates done");
	endtask
	task t_clash;
		int n;
		n = 0;
		tx_byte <= 8'h96;
		load <= 1'b1;
		apb(1'b1, sri_pkg::ADDR_CTRL, 8'hD3);
		load <= 1'b0;
		apb(1'b1, sri_pkg::ADDR_DATA, 8'h5A);
		apb(1'b1, sri_pkg::ADDR_DATA, 8'hFF);
		chk("irq on clash", 16'h0000, 16'(serial_irq));
		while (serial_irq !== 1'b1 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000)
			bail("done irq");
		apb(1'b1, sri_pkg::ADDR_DATA, 8'h11);
		repeat (100) @(posedge pclk);
		chk("peer after ignored write", 16'h005A, 16'(rx_byte));
		rchk(sri_pkg::ADDR_STATUS, 8'hC0, "clash and done");
		rchk(sri_pkg::ADDR_DATA, 8'h96, "rx kept");
		rchk(sri_pkg::ADDR_STATUS, 8'h00, "flags cleared");
		chk("irq cleared", 16'h0000, 16'(serial_irq));
		$display("test clash done");
	endtask
	task t_fault;
		int n;
		n = 0;
		select_n_in <= 1'b0;
		while (serial_irq !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20)
			bail("fault irq");
		select_n_in <= 1'b1;
		rchk(sri_pkg::ADDR_CTRL, 8'h83, "ctrl after fault");
		apb(1'b1, sri_pkg::ADDR_CTRL, 8'hD3);
		rchk(sri_pkg::ADDR_STATUS, 8'h10, "fault flag");
		rchk(sri_pkg::ADDR_CTRL, 8'h83, "enable forced off");
		apb(1'b1, sri_pkg::ADDR_CTRL, 8'h53);
		rchk(sri_pkg::ADDR_STATUS, 8'h00, "fault cleared");
		apb(1'b1, sri_pkg::ADDR_STATUS, 8'h03);
		select_n_in <= 1'b0;
		repeat (10) @(posedge pclk);
		rchk(sri_pkg::ADDR_STATUS, 8'h03, "soft select no fault");
		chk("select pin free", 16'h0001, 16'(select_pin_free));
		chk("mosi driven", 16'h0000, 16'(mosi_oe_n));
		apb(1'b1, sri_pkg::ADDR_STATUS, 8'h07);
		chk("mosi blocked", 16'h0001, 16'(mosi_oe_n));
		chk("sck driven", 16'h0000, 16'(sck_oe_n));
		apb(1'b1, sri_pkg::ADDR_CTRL, 8'h08);
		apb(1'b1, sri_pkg::ADDR_CTRL, 8'h58);
		chk("sck idle high", 16'h0001, 16'(sck_out));
		select_n_in <= 1'b1;
		$display("test fault done");
	endtask
	initial
	begin
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_rates;
		t_clash;
		t_fault;
		summarize;
	end
endmodule
bind sri_core sri_core_monitor #(.ADDR_W(ADDR_W)) sri_core_monitor_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pin_func_enable(pin_func_enable), .select_pin_free(select_pin_free),
	.sck_out(sck_out), .sck_oe_n(sck_oe_n), .miso_oe_n(miso_oe_n), .mosi_oe_n(mosi_oe_n),
	.select_n_in(select_n_in));
